// ===== pkg/itg_pkg.sv
// Constants for the interval timer block: register offsets, fields, reset values.
// Assumes a simple byte/word addressed register port on the system clock.
package itg_pkg;
  localparam logic [19:0] OFS_PER_ENABLE = 20'hf00f0;
  localparam logic [19:0] OFS_CLK_MODE   = 20'hf00f3;
  localparam logic [19:0] OFS_TMR_CTRL   = 20'hfff90;
  localparam int          GATE_BIT       = 7;
  localparam int          LOWPWR_BIT     = 7;
  localparam int          SLOWSEL_BIT    = 4;
  localparam int          RUN_BIT        = 15;
  localparam int          CMP_W          = 12;
  localparam logic [1:0]  SZ_BIT         = 2'h0;
  localparam logic [1:0]  SZ_BYTE        = 2'h1;
  localparam logic [1:0]  SZ_WORD        = 2'h2;
  localparam logic [7:0]  PER_RESET      = 8'h00;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [15:0] CTRL_RESET     = 16'h0fff;
  localparam logic [7:0]  MODE_MASK      = 8'h90;
  localparam logic [7:0]  PER_MASK       = 8'hb5;
  localparam logic [15:0] CTRL_MASK      = 16'h8fff;
  localparam logic [11:0] CNT_ZERO       = 12'h000;
  typedef enum logic [1:0] {
    ITG_ST_IDLE  = 2'b00,
    ITG_ST_ARMED = 2'b01,
    ITG_ST_RUN   = 2'b10
  } itg_state_t;
endpackage

// ===== hdl/itg_sync.sv
// Two-flop synchroniser for a free-running count clock level.
// Assumes the source is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module itg_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/itg_tick.sv
// Rising-edge detector turning a synchronised count clock into a one-cycle enable.
// Assumes the input already passed a synchroniser; gated by the clock-gate bit.
`timescale 1ns/1ps
`default_nettype none
module itg_tick (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic lvl,
  input  wire logic enable,
  output var  logic tick
);
  logic lvl_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      tick  <= 1'b0;
    end else begin
      lvl_q <= lvl;
      tick  <= enable & lvl & ~lvl_q;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/itg_timer.sv
// Interval timer with clock gating: register file, count clock select and 12-bit counter.
// Assumes count clocks arrive on pins asynchronous to clk, much slower than clk.
//
// Contract
// R1 - Interval interrupt repeats at the software-programmed period.
// R2 - Gate bit 0 stops count clock, blocks timer writes, holds timer reset.
// R3 - Gate bit 1 supplies count clock and allows register read and write.
// R4 - Gate low: timer writes ignored, reads give defaults; clock-mode register exempt.
// R5 - Software sets gate bit only after count clock is stable.
// R6 - Software keeps unused enable bits at zero.
// R7 - Low-power bit stops other peripheral clocks in halt and stop; the code stops them only while the select bit is 0.
// R8 - Select bit 0 picks subsystem clock, 1 picks low-speed oscillator.
// R9 - Select bit 0 allows clock-out pin to pick subsystem clock.
// R10 - Software keeps select at 0 while subsystem oscillator runs.
// R11 - Software changes select only with all run and enable bits zero.
// R12 - Timer run is bit 15 of timer control register.
// R13 - Clock-mode register is 8-bit written, clears to zero.
// R14 - Enable register takes bit and byte writes, clears to zero.
// R15 - Timer control register is 16-bit written, resets to 0fff.
// R16 - Control layout: run bit 15, zeros 14..12, compare 11..0.
// R17 - Clock-mode layout: low-power bit 7, select bit 4, others zero.
// R18 - Period equals count clock period times compare plus one.
// R19 - Counter counts up, clears on match, interrupt same cycle.
// R20 - Run 0 stops and clears counter; run 1 starts counting.
// R21 - Run bit readback updates one count clock cycle after write.
// R22 - Interrupt is a single-cycle pulse per match.
`timescale 1ns/1ps
`default_nettype none
module itg_timer #(
  parameter int CMP_W = itg_pkg::CMP_W
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port: one strobe per access, size selects bit, byte or word
  input  wire logic [19:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_size,
  input  wire logic [2:0]  reg_bit,
  input  wire logic        reg_bit_val,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  // Count clock sources, asynchronous to clk
  input  wire logic        sub_clock,
  input  wire logic        low_speed_osc_clock,
  // System state and neighbour run levels
  input  wire logic        halt_or_stop,
  input  wire logic        calendar_run,
  input  wire logic        display_scan_on,
  input  wire logic        display_boost_on,
  // Interrupt and clock generator status
  output var  logic        interval_irq,
  output var  logic        count_clock_gate,
  output var  logic        other_periph_clk_stop,
  output var  logic        clock_out_sub_allowed,
  output var  logic        count_clock_is_slow
);
  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic [7:0]       per_q;
  logic [7:0]       mode_q;
  logic [15:0]      ctrl_q;
  logic             run_on;
  logic [CMP_W-1:0] cnt_q;
  logic             calendar_timer_clock_gate;
  logic             low_power_sub_supply;
  logic             slow_clock_select;
  logic             interval_run;
  logic [CMP_W-1:0] compare_value;

  assign calendar_timer_clock_gate = per_q[itg_pkg::GATE_BIT];
  assign low_power_sub_supply      = mode_q[itg_pkg::LOWPWR_BIT];
  assign slow_clock_select         = mode_q[itg_pkg::SLOWSEL_BIT];
  assign interval_run              = ctrl_q[itg_pkg::RUN_BIT];               // R12
  assign compare_value             = ctrl_q[CMP_W-1:0];

  wire hit_per  = (reg_addr == itg_pkg::OFS_PER_ENABLE);
  wire hit_mode = (reg_addr == itg_pkg::OFS_CLK_MODE);
  wire hit_ctrl = (reg_addr == itg_pkg::OFS_TMR_CTRL);
  wire sz_bit   = (reg_size == itg_pkg::SZ_BIT);
  wire sz_byte  = (reg_size == itg_pkg::SZ_BYTE);
  wire sz_word  = (reg_size == itg_pkg::SZ_WORD);

  wire wr_per_byte = reg_wr & hit_per & sz_byte;                            // R14
  wire wr_per_bit  = reg_wr & hit_per & sz_bit;                             // R14
  wire wr_mode     = reg_wr & hit_mode & sz_byte;                           // R13
  wire wr_ctrl     = reg_wr & hit_ctrl & sz_word & calendar_timer_clock_gate; // R2 R4

  // One write path per enable bit; positions without a function never store a one
  wire [7:0]  per_d;
  for (genvar gi = 0; gi < $bits(per_q); gi++) begin : g_per
    wire bit_hit = wr_per_bit & (reg_bit == 3'(gi));
    wire bit_new = wr_per_byte ? reg_wdata[gi] : bit_hit ? reg_bit_val : per_q[gi];
    assign per_d[gi] = bit_new & itg_pkg::PER_MASK[gi];                       // R14
  end

  wire [7:0]  mode_d = wr_mode ? (reg_wdata[7:0] & itg_pkg::MODE_MASK) : mode_q; // R17
  wire [15:0] ctrl_d = !calendar_timer_clock_gate ? itg_pkg::CTRL_RESET :       // R2
                       wr_ctrl ? (reg_wdata & itg_pkg::CTRL_MASK) : ctrl_q;     // R16

  // Reads of the timer register show reset value while gated off
  wire [15:0] ctrl_view = calendar_timer_clock_gate ? {run_on, ctrl_q[14:0]} :  // R3 R21
                          itg_pkg::CTRL_RESET;                                  // R4
  logic [15:0] rdata_d;
  always_comb begin
    if (!reg_rd) begin
      rdata_d = reg_rdata;
    end else if (hit_per) begin
      rdata_d = {8'h00, per_q};
    end else if (hit_mode) begin
      rdata_d = {8'h00, mode_q};
    end else if (hit_ctrl) begin
      rdata_d = ctrl_view;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q     <= itg_pkg::PER_RESET;                                        // R14
      mode_q    <= itg_pkg::MODE_RESET;                                       // R13
      ctrl_q    <= itg_pkg::CTRL_RESET;                                       // R15
      reg_rdata <= 16'h0000;
    end else begin
      per_q     <= per_d;
      mode_q    <= mode_d;
      ctrl_q    <= ctrl_d;
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count clock selection and gating
  logic sub_s;
  logic slow_s;
  logic tick;
  itg_sync u_sync_sub (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (sub_clock),
    .q     (sub_s)
  );
  itg_sync u_sync_slow (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (low_speed_osc_clock),
    .q     (slow_s)
  );
  // Both clocks are synchronised all the time so a switch never sees a stale first stage
  wire sel_lvl = slow_clock_select ? slow_s : sub_s;                          // R8
  itg_tick u_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .lvl    (sel_lvl),
    .enable (calendar_timer_clock_gate),                                      // R2 R3
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run control: a written run bit takes effect on the next count tick
  itg_pkg::itg_state_t state_q;
  itg_pkg::itg_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      itg_pkg::ITG_ST_IDLE: begin
        if (interval_run && tick) begin
          state_d = itg_pkg::ITG_ST_RUN;
        end else if (interval_run) begin
          state_d = itg_pkg::ITG_ST_ARMED;
        end
      end
      itg_pkg::ITG_ST_ARMED: begin
        if (!interval_run) begin
          state_d = itg_pkg::ITG_ST_IDLE;
        end else if (tick) begin
          state_d = itg_pkg::ITG_ST_RUN;
        end
      end
      itg_pkg::ITG_ST_RUN: begin
        if (!interval_run && tick) begin
          state_d = itg_pkg::ITG_ST_IDLE;
        end
      end
      default: begin
        state_d = itg_pkg::ITG_ST_IDLE;
      end
    endcase
  end
  // Readback shows the applied run state, so it lags the written bit by one tick
  assign run_on = (state_q == itg_pkg::ITG_ST_RUN);                           // R21

  ////////////////////////////////////////////////////////////////////////////
  // Counter and interrupt
  // Switching the select while running may glitch one tick; software must stop first
  wire             match    = run_on & (cnt_q == compare_value);
  wire [CMP_W-1:0] cnt_next = cnt_q + 1'b1;                                   // R19
  wire [CMP_W-1:0] cnt_d    = (!run_on || match) ? '0 : cnt_next;             // R18 R19 R20
  wire             irq_d    = tick & match;                                   // R1 R19 R22
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= itg_pkg::ITG_ST_IDLE;
      cnt_q        <= itg_pkg::CNT_ZERO;
      interval_irq <= 1'b0;
    end else if (!calendar_timer_clock_gate) begin
      state_q      <= itg_pkg::ITG_ST_IDLE;                                   // R2
      cnt_q        <= itg_pkg::CNT_ZERO;
      interval_irq <= 1'b0;
    end else begin
      state_q      <= state_d;
      interval_irq <= irq_d;
      if (tick) begin
        cnt_q <= cnt_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs to the clock generator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_clock_gate      <= 1'b0;
      other_periph_clk_stop <= 1'b0;
      clock_out_sub_allowed <= 1'b1;
      count_clock_is_slow   <= 1'b0;
    end else begin
      count_clock_gate      <= calendar_timer_clock_gate;                     // R3
      other_periph_clk_stop <= low_power_sub_supply & ~slow_clock_select & halt_or_stop; // R7
      clock_out_sub_allowed <= ~slow_clock_select;                            // R9
      count_clock_is_slow   <= slow_clock_select;                             // R8
    end
  end

  // Run levels of neighbours are accepted but feed no logic or output
  wire unused_ok = calendar_run ^ display_scan_on ^ display_boost_on;
endmodule
`default_nettype wire

// ===== sim/itg_timer_sva.sv
// Port assertions for itg_timer.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module itg_timer_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [19:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        interval_irq,
  input wire logic        count_clock_gate,
  input wire logic        other_periph_clk_stop,
  input wire logic        clock_out_sub_allowed,
  input wire logic        count_clock_is_slow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_per = reg_rd && reg_addr == 20'hf00f0;
  wire rd_mode = reg_rd && reg_addr == 20'hf00f3;
  wire rd_ctl = reg_rd && reg_addr == 20'hfff90;
  chk_irq_pulse: assert property (interval_irq |=> !interval_irq) else $error("irq too long");
  chk_irq_gated: assert property (!count_clock_gate [*2] |-> !interval_irq) else $error("irq gated");
  chk_sel_pair: assert property (clock_out_sub_allowed != count_clock_is_slow) else $error("select pair");
  chk_mode_bits: assert property (rd_mode |=> (reg_rdata & 16'hff6f) == 16'h0000) else $error("mode bits");
  chk_per_bits: assert property (rd_per |=> (reg_rdata & 16'hff4a) == 16'h0000) else $error("enable bits");
  chk_ctl_zeros: assert property (rd_ctl |=> reg_rdata[14:12] == 3'h0) else $error("control bits");
  chk_ctl_gated: assert property (!count_clock_gate [*2] ##0 rd_ctl |=> reg_rdata == 16'h0fff)
    else $error("gated read");
  chk_stop_cause: assert property (other_periph_clk_stop |-> !count_clock_is_slow) else $error("bad stop");
  cover property (interval_irq && count_clock_is_slow);
  cover property (other_periph_clk_stop);
  cover property (rd_ctl ##1 count_clock_gate);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind itg_timer itg_timer_sva i_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .interval_irq(interval_irq), .count_clock_gate(count_clock_gate),
  .other_periph_clk_stop(other_periph_clk_stop), .clock_out_sub_allowed(clock_out_sub_allowed),
  .count_clock_is_slow(count_clock_is_slow));
`default_nettype wire

// ===== sim/itg_timer_tb.sv
// Self-checking bench for itg_timer: register access, gating, interrupt period.
// Count clocks are derived from clk here, so tick spacing is exact.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module itg_timer_tb;
  logic        clk, rst_n, wr, rd, halt, irq, gate, stop, allow, slow, sub_on;
  logic [1:0]  sz;
  logic [15:0] wd, rdat;
  logic [19:0] addr;
  int          num_errors = 0, tests_run = 0, cyc = 0, n;
  // Subsystem oscillator runs only while the slow clock is not selected
  wire         sub_ck = sub_on && cyc % 10 < 5;
  wire         slow_ck = cyc % 14 < 7;
  itg_timer i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_size(sz),
    .reg_bit(wd[2:0]), .reg_bit_val(wd[3]), .reg_wdata(wd), .reg_rdata(rdat), .sub_clock(sub_ck),
    .low_speed_osc_clock(slow_ck), .halt_or_stop(halt), .calendar_run(1'b0), .display_scan_on(1'b0),
    .display_boost_on(1'b0), .interval_irq(irq), .count_clock_gate(gate), .other_periph_clk_stop(stop),
    .clock_out_sub_allowed(allow), .count_clock_is_slow(slow));
  initial forever #4 clk = ~clk;
  always @(posedge clk) cyc <= #1 cyc + 1;
////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic [19:0] a, input logic [1:0] s, input logic [15:0] d, input logic w);
    @(posedge clk);
    #1 {addr, sz, wd, wr, rd} = {a, s, d, w, !w};
    @(posedge clk);
    #1 {wr, rd} = 2'b00;
    @(posedge clk);
    #1;
  endtask
  task automatic rchk(input logic [19:0] a, input logic [1:0] s, input logic [15:0] e, input string nm);
    acc(a, s, 16'h0000, 1'b0);
    `CHK(nm, e, rdat)
  endtask
  // The limit doubles as the idle window while the timer is stopped
  task automatic gap;
    for (n = 1; n < 3000; n++) begin
      @(posedge clk);
      #1 if (irq === 1'b1) break;
    end
  endtask
  task automatic t_regs;
    rchk(20'hf00f0, 2'h1, 16'h0000, "enable");
    rchk(20'hfff90, 2'h2, 16'h0fff, "ctrl");
    acc(20'hfff90, 2'h2, 16'h8005, 1'b1);
    rchk(20'hfff90, 2'h2, 16'h0fff, "ctrl gated");
    acc(20'hf00f3, 2'h1, 16'h00ff, 1'b1);
    rchk(20'hf00f3, 2'h1, 16'h0090, "mode");
    `CHK("allow", 1'b0, allow)
    `CHK("slow", 1'b1, slow)
    acc(20'hf00f3, 2'h2, 16'h0000, 1'b1);
    rchk(20'hf00f3, 2'h1, 16'h0090, "mode size");
    acc(20'hf00f0, 2'h0, 16'h000f, 1'b1);
    `CHK("gate", 1'b1, gate)
    acc(20'hfff90, 2'h2, 16'h0005, 1'b1);
    rchk(20'hfff90, 2'h2, 16'h0005, "ctrl open");
    acc(20'hf00f0, 2'h0, 16'h0007, 1'b1);
    rchk(20'hfff90, 2'h2, 16'h0fff, "ctrl cleared");
    `CHK("gate off", 1'b0, gate)
    acc(20'hf00f0, 2'h1, 16'h0080, 1'b1);
    rchk(20'hf00f0, 2'h1, 16'h0080, "enable byte");
    $display("test regs done");
  endtask
  task automatic t_run(input logic [7:0] m, input int p, input logic [11:0] c);
    acc(20'hf00f0, 2'h1, 16'h0000, 1'b1);
    sub_on = 1'b0;
    acc(20'hf00f3, 2'h1, {8'h00, m}, 1'b1);
    sub_on = !m[4];
    acc(20'hf00f0, 2'h1, 16'h0080, 1'b1);
    acc(20'hfff90, 2'h2, {4'h8, c}, 1'b1);
    halt = 1'b1;
    gap();
    gap();
    `CHK("period", (c + 1) * p, n)
    `CHK("stop", ~m[4], stop)
    rchk(20'hfff90, 2'h2, {4'h8, c}, "run");
    acc(20'hfff90, 2'h2, {4'h0, c}, 1'b1);
    gap();
    `CHK("idle", 3000, n)
    $display("test run done");
  endtask
  initial begin
    {clk, rst_n, wr, rd, halt, sub_on, sz, wd, addr} = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_run(8'h80, 10, 12'h00f);
    t_run(8'h90, 14, 12'h001);
    stop_test();
  end
  initial begin
    #200000;
    num_errors++;
    $display("BAD watchdog exp end got hang");
    stop_test();
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
endmodule
`default_nettype wire
